// ==== src/host_clock_single_pulse_ctrl_map.vh ====
/*
  register offsets, field positions and reset values of the single-pulse
  control bank. assumes a byte-wide register port fed by an smbus engine.
*/
`ifndef HOST_CLOCK_SINGLE_PULSE_CTRL_MAP_VH
`define HOST_CLOCK_SINGLE_PULSE_CTRL_MAP_VH
`define BYTE_COUNT_ADDR        4'h6
`define VENDOR_RESERVED_A_ADDR 4'h7
`define SINGLE_PULSE_CTRL_ADDR 4'h8
`define BYTE_COUNT_RESET       8'h07
`define VENDOR_RESERVED_RESET  8'h00
`define SINGLE_PULSE_RESET     8'h00
`define VENDOR_RESERVED_WMASK  8'hFC
`define FIRE_BIT               7
`define ARM_BIT                6
`define PAIR_ONE_EN_BIT        7
`define PAIR_ZERO_EN_BIT       6
`define HALF_PERIOD_DEFAULT    8'h01
`endif

// ==== src/host_clock_single_pulse_ctrl.v ====
/*
  single-pulse control bank: byte count, reserved vendor byte and the
  arm/fire control byte, plus the host clock pair output stage.
  assumes the smbus engine presents one decoded byte write per transaction
  with wr_done pulsing once the whole write protocol has completed, and
  that all inputs are synchronous to mclk.
*/
`timescale 1ns/1ps
`include "host_clock_single_pulse_ctrl_map.vh"

module host_clock_single_pulse_ctrl (
  // clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // register port from the smbus engine
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       wr_done,
  output reg  [7:0] reg_rdata,
  // host pair enables and half period in mclk cycles
  input  wire [7:0] pair_enable,
  input  wire [7:0] half_period,
  // other clocks, gated only by their own enables
  input  wire       other_clk_in,
  input  wire       other_clk_en,
  output reg        other_clk_out,
  // host clock pair outputs
  output reg        host_clock_pair_zero,
  output reg        host_clock_pair_zero_n,
  output reg        host_clock_pair_one,
  output reg        host_clock_pair_one_n
);

  // stored registers and their next values
  reg  [7:0] byte_count_reg;
  reg  [7:0] byte_count_next;
  reg  [7:0] vendor_reserved_a_reg;
  reg  [7:0] vendor_reserved_a_next;
  reg  [7:0] single_pulse_control_reg;
  reg  [7:0] single_pulse_control_next;
  // pulse sequencing state
  reg        fire_seen_reg;
  reg        fire_seen_next;
  reg        fire_pending_reg;
  reg        fire_pending_next;
  reg        pulse_active_reg;
  reg        pulse_active_next;
  // internal free-running host clock
  reg  [7:0] phase_cnt_reg;
  reg  [7:0] phase_cnt_next;
  reg        host_clk_reg;
  reg        host_clk_next;
  // decoded strobes and shared terms
  wire [7:0] half_len;
  wire       phase_wrap;
  wire       rising_phase;
  wire       armed;
  wire       fire_level;
  wire       fire_edge;
  wire       wr_byte_count;
  wire       wr_vendor;
  wire       wr_control;
  // output stage next values
  reg  [7:0] rdata_next;
  reg        true_next;
  reg        pair_zero_next;
  reg        pair_zero_n_next;
  reg        pair_one_next;
  reg        pair_one_n_next;
  reg        other_clk_next;

  // a zero half period would wrap only at a count of 255, so it runs as one
  assign half_len      = (half_period == 8'h00) ? `HALF_PERIOD_DEFAULT : half_period;
  assign phase_wrap    = (phase_cnt_reg >= half_len - 8'h01);
  assign rising_phase  = phase_wrap & ~host_clk_reg;
  assign armed         = single_pulse_control_reg[`ARM_BIT];
  assign fire_level    = single_pulse_control_reg[`FIRE_BIT];
  assign fire_edge     = wr_done & armed & fire_level & ~fire_seen_reg;
  assign wr_byte_count = reg_wr & (reg_addr == `BYTE_COUNT_ADDR);
  assign wr_vendor     = reg_wr & (reg_addr == `VENDOR_RESERVED_A_ADDR);
  assign wr_control    = reg_wr & (reg_addr == `SINGLE_PULSE_CTRL_ADDR);

  // register writes take effect at once; the pulse waits for wr_done
  always @* begin
    byte_count_next = byte_count_reg;
    if (wr_byte_count) begin
      byte_count_next = reg_wdata;
    end
  end

  always @* begin
    vendor_reserved_a_next = vendor_reserved_a_reg;
    if (wr_vendor) begin
      vendor_reserved_a_next = reg_wdata & `VENDOR_RESERVED_WMASK;
    end
  end

  always @* begin
    single_pulse_control_next = single_pulse_control_reg;
    if (wr_control) begin
      single_pulse_control_next = reg_wdata;
    end
  end

  // power-up values come only from the reset branch
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_count_reg <= `BYTE_COUNT_RESET;
    end else begin
      byte_count_reg <= byte_count_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vendor_reserved_a_reg <= `VENDOR_RESERVED_RESET;
    end else begin
      vendor_reserved_a_reg <= vendor_reserved_a_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      single_pulse_control_reg <= `SINGLE_PULSE_RESET;
    end else begin
      single_pulse_control_reg <= single_pulse_control_next;
    end
  end

  // unmapped indices read zero
  always @* begin
    case (reg_addr)
      `BYTE_COUNT_ADDR: begin
        rdata_next = byte_count_reg;
      end
      `VENDOR_RESERVED_A_ADDR: begin
        rdata_next = vendor_reserved_a_reg;
      end
      `SINGLE_PULSE_CTRL_ADDR: begin
        rdata_next = single_pulse_control_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // free-running host clock; keeps running while armed so the pulse width is exact
  always @* begin
    phase_cnt_next = phase_cnt_reg + 8'h01;
    host_clk_next  = host_clk_reg;
    if (phase_wrap) begin
      phase_cnt_next = 8'h00;
      host_clk_next  = ~host_clk_reg;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_cnt_reg <= 8'h00;
      host_clk_reg  <= 1'b0;
    end else begin
      phase_cnt_reg <= phase_cnt_next;
      host_clk_reg  <= host_clk_next;
    end
  end

  // history moves only at completion, so a stored one never fires twice
  always @* begin
    fire_seen_next = fire_seen_reg;
    if (wr_done) begin
      fire_seen_next = fire_level;
    end
  end

  // a pending shot is kept until the next rising phase takes it or the arm bit clears
  always @* begin
    fire_pending_next = fire_pending_reg;
    if (fire_edge) begin
      fire_pending_next = 1'b1;
    end else if (!armed || (fire_pending_reg && rising_phase)) begin
      fire_pending_next = 1'b0;
    end
  end

  // start only as the internal clock rises, so the high phase is whole
  always @* begin
    pulse_active_next = pulse_active_reg;
    if (!armed) begin
      pulse_active_next = 1'b0;
    end else if (fire_pending_reg && rising_phase) begin
      pulse_active_next = 1'b1;
    end else if (pulse_active_reg && phase_wrap) begin
      pulse_active_next = 1'b0;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fire_seen_reg <= 1'b0;
    end else begin
      fire_seen_reg <= fire_seen_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fire_pending_reg <= 1'b0;
    end else begin
      fire_pending_reg <= fire_pending_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_active_reg <= 1'b0;
    end else begin
      pulse_active_reg <= pulse_active_next;
    end
  end

  // disarming mid-pulse hands over to host_clk_reg, which is high in the same phase, so the pulse is not cut short
  always @* begin
    if (armed) begin
      true_next = pulse_active_reg;
    end else begin
      true_next = host_clk_reg;
    end
  end

  // a disabled pair is low on both legs, armed or not
  always @* begin
    if (pair_enable[`PAIR_ZERO_EN_BIT]) begin
      pair_zero_next   = true_next;
      pair_zero_n_next = ~true_next;
    end else begin
      pair_zero_next   = 1'b0;
      pair_zero_n_next = 1'b0;
    end
  end

  always @* begin
    if (pair_enable[`PAIR_ONE_EN_BIT]) begin
      pair_one_next   = true_next;
      pair_one_n_next = ~true_next;
    end else begin
      pair_one_next   = 1'b0;
      pair_one_n_next = 1'b0;
    end
  end

  // other clocks see only their own enable, never the arm bit
  always @* begin
    other_clk_next = other_clk_in & other_clk_en;
  end

  // pair outputs; armed idle parks true low and complement high
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      host_clock_pair_zero   <= 1'b0;
      host_clock_pair_zero_n <= 1'b0;
    end else begin
      host_clock_pair_zero   <= pair_zero_next;
      host_clock_pair_zero_n <= pair_zero_n_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      host_clock_pair_one   <= 1'b0;
      host_clock_pair_one_n <= 1'b0;
    end else begin
      host_clock_pair_one   <= pair_one_next;
      host_clock_pair_one_n <= pair_one_n_next;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      other_clk_out <= 1'b0;
    end else begin
      other_clk_out <= other_clk_next;
    end
  end

endmodule // host_clock_single_pulse_ctrl

// ==== tb/hcsp_monitor.sv ====
/* checker on the bank ports; assumes one mclk domain, bound to the bank at the foot */
`timescale 1ns/1ps
module hcsp_monitor (input wire mclk, sys_rst, reg_wr, wr_done, other_clk_in, other_clk_en, other_clk_out,
  input wire [3:0] reg_addr, input wire [7:0] reg_wdata, reg_rdata, pair_enable, half_period,
  input wire host_clock_pair_zero, host_clock_pair_zero_n, host_clock_pair_one, host_clock_pair_one_n);
  reg  [7:0] ctl_reg, since_reg, hi_reg;
  reg        fire_reg;
  // a fire counts only armed, bit set now and clear at the previous completion
  wire       qual = wr_done && ctl_reg[7] && ctl_reg[6] && !fire_reg;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_reg <= 8'h00; since_reg <= 8'hFF; hi_reg <= 8'h00; fire_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h8) ctl_reg <= reg_wdata;
      if (wr_done) fire_reg <= ctl_reg[7];
      since_reg <= qual ? 8'h00 : since_reg + {7'h00, since_reg != 8'hFF};
      hi_reg <= host_clock_pair_zero ? hi_reg + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rdata; $past(reg_addr) == 4'h8 && !$past(reg_wr) |-> reg_rdata == ctl_reg; endproperty
  a_rdata: assert property (p_rdata) else $error("control readback wrong");
  property p_vendor; $past(reg_addr) == 4'h7 |-> reg_rdata[1:0] == 2'h0; endproperty
  a_vendor: assert property (p_vendor) else $error("read-only vendor bits set");
  property p_one_off; (!pair_enable[7]) [*2] |-> !host_clock_pair_one && !host_clock_pair_one_n; endproperty
  a_one_off: assert property (p_one_off) else $error("disabled pair not low");
  property p_pair; (pair_enable[6] && !sys_rst) [*2] |-> host_clock_pair_zero_n != host_clock_pair_zero; endproperty
  a_pair: assert property (p_pair) else $error("complement not inverse");
  property p_other; 1'b1 |=> other_clk_out == $past(other_clk_in && other_clk_en); endproperty
  a_other: assert property (p_other) else $error("other clock stalled");
  property p_stray;
    ctl_reg[6] && $past(ctl_reg[6], 8) && $rose(host_clock_pair_zero) |-> since_reg <= {half_period, 1'b0} + 9'h004;
  endproperty
  a_stray: assert property (p_stray) else $error("pulse without fire edge");
  property p_fires; qual && pair_enable[6] |-> ##[1:14] $rose(host_clock_pair_zero); endproperty
  a_fires: assert property (p_fires) else $error("fire gave no pulse");
  property p_width; ctl_reg[6] && $past(ctl_reg[6], 8) && $fell(host_clock_pair_zero) |-> hi_reg == half_period; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_resume; $fell(ctl_reg[6]) && pair_enable[6] |-> ##[1:14] $rose(host_clock_pair_zero); endproperty
  a_resume: assert property (p_resume) else $error("clock not resumed");
endmodule // hcsp_monitor
bind host_clock_single_pulse_ctrl hcsp_monitor i_mon (.*);

// ==== tb/smbus_host_model.sv ====
/* host stand-in: one byte write per go pulse, completion a cycle later; mclk domain */
`timescale 1ns/1ps
module smbus_host_model (input wire mclk, go, input wire [3:0] addr, input wire [7:0] data,
  output wire [3:0] reg_addr, output reg [7:0] reg_wdata, output reg reg_wr, wr_done);
  assign reg_addr = addr;
  initial {reg_wr, wr_done, reg_wdata} = 10'h000;
  always @(posedge mclk) begin
    reg_wr <= go;
    wr_done <= reg_wr;
    // idle data keeps moving so a stale byte is never mistaken for a write
    reg_wdata <= go ? data : ~reg_wdata;
  end
endmodule // smbus_host_model

// ==== tb/host_clock_single_pulse_ctrl_tb.sv ====
/* bench for the pulse bank: host model writes, bench reads back and counts pulses */
`timescale 1ns/1ps
module host_clock_single_pulse_ctrl_tb;
  reg         mclk = 0, sys_rst = 1, go = 0, other_clk_in = 0, other_clk_en = 0;
  reg  [3:0]  addr = 4'h0;
  reg  [7:0]  data = 8'h00, pe = 8'hC0, hp = 8'h04, b;
  wire [3:0]  reg_addr;
  wire [7:0]  reg_wdata, reg_rdata;
  wire        reg_wr, wr_done, oc, z, zn, o, onn;
  integer     seed = 5258, err_count = 0, total_checks = 0, r;
  always #5 mclk = ~mclk;
  always @(posedge mclk) {other_clk_en, other_clk_in} <= 2'($random(seed));
  smbus_host_model i_host (.mclk(mclk), .go(go), .addr(addr), .data(data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .wr_done(wr_done));
  host_clock_single_pulse_ctrl i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .wr_done(wr_done), .reg_rdata(reg_rdata), .pair_enable(pe), .half_period(hp),
    .other_clk_in(other_clk_in), .other_clk_en(other_clk_en), .other_clk_out(oc), .host_clock_pair_zero(z),
    .host_clock_pair_zero_n(zn), .host_clock_pair_one(o), .host_clock_pair_one_n(onn));
  task wr(input [3:0] a, input [7:0] d); begin
    addr <= a; data <= d; go <= 1'b1; @(posedge mclk); go <= 1'b0; @(posedge mclk); end endtask
  task rd(input [3:0] a, input [7:0] e); begin
    addr <= a; repeat (3) @(posedge mclk); @(negedge mclk); total_checks++;
    if (reg_rdata !== e) begin err_count++; $display("ERROR at %0t: read %h got %h", $time, a, reg_rdata); end
    @(posedge mclk);
  end endtask
  // negative expectation means at least one rising edge
  task watch(input integer n, ez, eo); integer i, cz, co; reg pz, po; begin
    cz = 0; co = 0; @(negedge mclk); pz = z; po = o;
    for (i = 0; i < n; i++) begin
      @(negedge mclk); cz += (z === 1'b1 && pz !== 1'b1); co += (o === 1'b1 && po !== 1'b1); pz = z; po = o;
    end
    @(posedge mclk);
    total_checks++;
    if ((ez < 0 ? cz < 1 : cz != ez) || (eo < 0 ? co < 1 : co != eo)) begin
      err_count++; $display("ERROR at %0t: pulses %0d %0d", $time, cz, co); end
  end endtask
  task give_verdict; begin
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  initial begin
    #50000; err_count++; $display("ERROR at %0t: watchdog", $time); give_verdict;
  end
  initial begin
    for (r = 0; r < 2; r++) begin
      // half period only changes under reset so every high run is whole
      sys_rst <= 1'b1; pe <= 8'hC0; hp <= r ? 8'h01 + {6'h00, 2'($random(seed))} : 8'h04;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0; @(posedge mclk);
      rd(4'h6, 8'h07);
      rd(4'h7, 8'h00);
      rd(4'h8, 8'h00);
      rd(4'h3, 8'h00);
      b = 8'($random(seed)); wr(4'h6, b); rd(4'h6, b);
      wr(4'h7, 8'hFF); rd(4'h7, 8'hFC); wr(4'h7, 8'h00);
      watch(40, -1, -1);
      pe <= 8'h40; wr(4'h8, 8'h40); repeat (4) @(posedge mclk); watch(30, 0, 0);
      wr(4'h8, 8'hC0); watch(30, 1, 0);
      wr(4'h8, 8'hC0); watch(30, 0, 0);
      wr(4'h8, 8'h40); wr(4'h8, 8'hC0); watch(30, 1, 0);
      wr(4'h8, 8'h00); watch(30, -1, 0);
      $display("round %0d done", r);
    end
    give_verdict;
  end
endmodule // host_clock_single_pulse_ctrl_tb
